// ---- hw/bts_boot_mode_select_regs.svh ----
// Purpose: Constants for the boot mode selection block
// Assumes: Included by bare name, definitions only
// Notes:   Code order is eprom, link, memory select (msb first)
//
// Overview of operation
// - Eprom select high, link select low: boot from 8-bit EPROM
// - Eprom select low: other two inputs decide
// - Link select high, memory select high: boot through link port
// - Link select low: host boot or none
// - Code 10: drive pin as EPROM select
// - Only bus master drives the select pin
// - Pin input low, other two inputs low: skip boot, run external
// - Pin driven only in EPROM mode
// - Code 001 selects host processor boot
// - Code 011 selects link port boot
// - Code 000 means no boot, external memory
`ifndef BTS_BOOT_MODE_SELECT_REGS_SVH
`define BTS_BOOT_MODE_SELECT_REGS_SVH

// ****************************************
// Configuration code layout
// ****************************************
`define BTS_CODE_W        3
`define BTS_CODE_EPROM    2
`define BTS_CODE_LINK     1
`define BTS_CODE_MEMSEL   0

// ****************************************
// Reset values
// ****************************************
`define BTS_RST_PIN_OUT   1'b1
`define BTS_RST_PIN_OE    1'b0
`define BTS_RST_VALID     1'b0
`define BTS_RST_CODE      3'h0
`define BTS_RST_FETCH     1'b0
`define BTS_RST_RSV       1'b0

`endif

// ---- hw/bts_pkg.sv ----
// Purpose: Types for the boot mode selection block
// Assumes: Nothing
// Notes:   One-hot encodings throughout
package bts_pkg;

  // Decoded boot outcome
  typedef enum logic [4:0] {
    BTS_MODE_NONE     = 5'h01,
    BTS_MODE_HOST     = 5'h02,
    BTS_MODE_LINK     = 5'h04,
    BTS_MODE_EPROM    = 5'h08,
    BTS_MODE_RESERVED = 5'h10
  } bts_mode_e;

  // Capture sequencer states
  typedef enum logic [1:0] {
    BTS_ST_WAIT = 2'h1,
    BTS_ST_HOLD = 2'h2
  } bts_state_e;

endpackage

// ---- hw/bts_mode_decode.sv ----
// Purpose: Decode the three configuration inputs into a boot mode
// Assumes: Inputs already sampled
// Notes:   Purely combinational
`timescale 1ns/1ns
`include "bts_boot_mode_select_regs.svh"

module bts_mode_decode (
  // Configuration code
  input  wire logic [`BTS_CODE_W-1:0] code_i,
  // Decoded mode
  output bts_pkg::bts_mode_e          mode_o
);
  import bts_pkg::*;

  always_comb begin
    if (code_i[`BTS_CODE_EPROM]) begin
      if (code_i[`BTS_CODE_LINK]) begin
        mode_o = BTS_MODE_RESERVED;
      end else begin
        mode_o = BTS_MODE_EPROM;
      end
    end else if (code_i[`BTS_CODE_LINK]) begin
      if (code_i[`BTS_CODE_MEMSEL]) begin
        mode_o = BTS_MODE_LINK;
      end else begin
        mode_o = BTS_MODE_RESERVED;
      end
    end else if (code_i[`BTS_CODE_MEMSEL]) begin
      mode_o = BTS_MODE_HOST;
    end else begin
      mode_o = BTS_MODE_NONE;
    end
  end

endmodule // bts_mode_decode

// ---- hw/bts_boot_mode_select.sv ----
// Purpose: Boot mode capture and boot memory select pin control
// Assumes: Configuration inputs hardwired, synchronous to the clock
// Notes:   Mode is taken on the first edge after reset release
`timescale 1ns/1ns
`include "bts_boot_mode_select_regs.svh"

module bts_boot_mode_select (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // Configuration inputs
  input  wire logic        eprom_boot_select_i,
  input  wire logic        link_boot_select_i,
  // Boot memory select pin
  input  wire logic        boot_memory_select_i,
  output logic             boot_memory_select_o,
  output logic             boot_memory_select_oe_o,
  // Core side
  input  wire logic        bus_master_i,
  input  wire logic        boot_cs_req_i,
  // Status
  output bts_pkg::bts_mode_e boot_mode_o,
  output logic             mode_valid_o,
  output logic             fetch_external_o,
  output logic             cfg_reserved_o
);
  import bts_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  bts_state_e              state;
  bts_state_e              next_state;
  bts_mode_e               dec_mode;
  bts_mode_e               next_boot_mode;
  logic                    next_mode_valid;
  logic                    next_fetch_external;
  logic                    next_cfg_reserved;
  logic                    next_pin_out;
  logic                    next_pin_oe;
  logic [`BTS_CODE_W-1:0]  code_now;
  logic [`BTS_CODE_W-1:0]  cap_code;
  logic [`BTS_CODE_W-1:0]  next_cap_code;

  assign code_now = {eprom_boot_select_i, link_boot_select_i,
                     boot_memory_select_i};

  // ****************************************
  // Mode decode
  // ****************************************
  bts_mode_decode u_decode (
    .code_i (code_now),
    .mode_o (dec_mode)
  );

  // ****************************************
  // Capture sequencer
  // ****************************************
  always_comb begin
    next_state          = state;
    next_boot_mode      = boot_mode_o;
    next_mode_valid     = mode_valid_o;
    next_fetch_external = fetch_external_o;
    next_cfg_reserved   = cfg_reserved_o;
    next_cap_code       = cap_code;
    case (state)
      BTS_ST_WAIT: begin
        next_state          = BTS_ST_HOLD;
        next_boot_mode      = dec_mode;
        next_mode_valid     = 1'b1;
        next_cap_code       = code_now;
        next_fetch_external = (dec_mode == BTS_MODE_NONE);
        next_cfg_reserved   = (dec_mode == BTS_MODE_RESERVED);
      end
      BTS_ST_HOLD: begin
        next_state = BTS_ST_HOLD;
      end
      default: begin
        next_state      = BTS_ST_WAIT;
        next_mode_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state            <= BTS_ST_WAIT;
      boot_mode_o      <= BTS_MODE_NONE;
      mode_valid_o     <= `BTS_RST_VALID;
      fetch_external_o <= `BTS_RST_FETCH;
      cfg_reserved_o   <= `BTS_RST_RSV;
      cap_code         <= `BTS_RST_CODE;
    end else begin
      state            <= next_state;
      boot_mode_o      <= next_boot_mode;
      mode_valid_o     <= next_mode_valid;
      fetch_external_o <= next_fetch_external;
      cfg_reserved_o   <= next_cfg_reserved;
      cap_code         <= next_cap_code;
    end
  end

  // ****************************************
  // Boot memory select pin
  // ****************************************
  // Outside EPROM mode the pin is only a configuration input
  always_comb begin
    next_pin_oe  = `BTS_RST_PIN_OE;
    next_pin_out = `BTS_RST_PIN_OUT;
    if (mode_valid_o && (boot_mode_o == BTS_MODE_EPROM)) begin
      next_pin_oe  = bus_master_i;
      next_pin_out = ~(bus_master_i & boot_cs_req_i);
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      boot_memory_select_oe_o <= `BTS_RST_PIN_OE;
      boot_memory_select_o    <= `BTS_RST_PIN_OUT;
    end else begin
      boot_memory_select_oe_o <= next_pin_oe;
      boot_memory_select_o    <= next_pin_out;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence seq_capture;
    state == BTS_ST_WAIT;
  endsequence

  sequence seq_eprom_master;
    mode_valid_o && (boot_mode_o == BTS_MODE_EPROM) && bus_master_i;
  endsequence

  AST_EPROM_BOOT: assert property (
    seq_capture and (eprom_boot_select_i && !link_boot_select_i)
    |=> boot_mode_o == BTS_MODE_EPROM && mode_valid_o)
    else $error("eprom code did not select eprom boot");

  AST_EPROM_LOW: assert property (
    seq_capture and !eprom_boot_select_i
    |=> boot_mode_o != BTS_MODE_EPROM)
    else $error("eprom boot chosen with eprom select low");

  AST_LINK_BOOT: assert property (
    seq_capture and (!eprom_boot_select_i && link_boot_select_i)
    |=> boot_mode_o inside {BTS_MODE_LINK, BTS_MODE_RESERVED})
    else $error("link select high did not pick link boot");

  AST_LINK_LOW: assert property (
    seq_capture and (!eprom_boot_select_i && !link_boot_select_i)
    |=> boot_mode_o inside {BTS_MODE_HOST, BTS_MODE_NONE})
    else $error("link select low gave neither host nor none");

  AST_PIN_DRIVE: assert property (
    seq_eprom_master |=> boot_memory_select_oe_o
      && (boot_memory_select_o == !$past(boot_cs_req_i)))
    else $error("select pin not driven as eprom chip select");

  AST_ONLY_MASTER: assert property (
    !bus_master_i |=> !boot_memory_select_oe_o)
    else $error("select pin driven without bus mastership");

  AST_NO_BOOT_FETCH: assert property (
    seq_capture and (code_now == 3'h0)
    |=> fetch_external_o ##1 fetch_external_o)
    else $error("low select input did not start external fetch");

  AST_TRISTATE_EPROM: assert property (
    boot_memory_select_oe_o |-> $past(boot_mode_o) == BTS_MODE_EPROM
      && $past(mode_valid_o))
    else $error("select pin driven outside eprom mode");

  AST_HOST_CODE: assert property (
    seq_capture and (code_now == 3'h1) |=> boot_mode_o == BTS_MODE_HOST)
    else $error("code 001 did not select host boot");

  AST_LINK_CODE: assert property (
    seq_capture and (code_now == 3'h3) |=> boot_mode_o == BTS_MODE_LINK)
    else $error("code 011 did not select link boot");

  AST_NONE_CODE: assert property (
    seq_capture and (code_now == 3'h0) |=> boot_mode_o == BTS_MODE_NONE)
    else $error("code 000 did not select no boot");

  AST_MODE_HELD: assert property (
    mode_valid_o |=> mode_valid_o && $stable(boot_mode_o)
      && $stable(cap_code))
    else $error("captured boot mode changed before reset");

  AST_FIRST_CAPTURE: assert property (
    seq_capture |=> mode_valid_o ##1 (state == BTS_ST_HOLD))
    else $error("mode not captured on first edge after reset");

  AST_NO_DRIVE_OTHER: assert property (
    mode_valid_o && (boot_mode_o != BTS_MODE_EPROM)
    |=> !boot_memory_select_oe_o)
    else $error("select pin driven while mode is not eprom");

  AST_CS_IDLE: assert property (
    !boot_memory_select_oe_o |-> boot_memory_select_o)
    else $error("chip select low while pin not driven");

  AST_CS_RELEASE: assert property (
    mode_valid_o && (boot_mode_o == BTS_MODE_EPROM) && !boot_cs_req_i
    |=> boot_memory_select_o)
    else $error("chip select low without a request");

  AST_FETCH_NONE: assert property (
    fetch_external_o |-> mode_valid_o && (boot_mode_o == BTS_MODE_NONE))
    else $error("external fetch flagged without no-boot mode");

  AST_EPROM_NO_FLAGS: assert property (
    seq_capture and (eprom_boot_select_i && !link_boot_select_i)
    |=> !fetch_external_o && !cfg_reserved_o)
    else $error("eprom boot raised a status flag");

  AST_RESERVED_FLAG: assert property (
    seq_capture and (code_now == 3'h2)
    |=> cfg_reserved_o && !fetch_external_o)
    else $error("code 010 not flagged as reserved");

  AST_VALID_ONLY_HOLD: assert property (
    mode_valid_o |-> state == BTS_ST_HOLD)
    else $error("mode valid outside the hold state");

endmodule // bts_boot_mode_select

// ---- bench/bts_strap_model.sv ----
// Purpose: Far-side model of the boot memory select pin
// Assumes: The configuration level is a fixed strap on the board
// Notes:   Stands for both the strap and the EPROM chip select load
`timescale 1ns/1ns
module bts_strap_model (
  // Board strap and device drive
  input  wire logic strap_i,
  input  wire logic drv_oe_i,
  input  wire logic drv_out_i,
  // Resolved pin level
  output logic      pin_o
);
  // The strap holds its level; reserved codes only when the bench asks
  assign pin_o = drv_oe_i ? drv_out_i : strap_i;
endmodule // bts_strap_model

// ---- bench/tb_boot_mode_select.sv ----
// Purpose: Self-checking bench for boot mode selection
// Assumes: Strap model resolves the boot memory select pin
// Notes:   Every code is captured, then pin drive and hold are checked
`timescale 1ns/1ns
module tb_boot_mode_select;
  import bts_pkg::*;
  logic        clk_sys_i  = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic        eprom_sel  = 1'b0;
  logic        link_sel   = 1'b0;
  logic        strap      = 1'b0;
  logic        bus_master = 1'b0;
  logic        cs_req     = 1'b0;
  logic        pin_on     = 1'b0;
  logic        valid_q    = 1'b0;
  logic        pin, pin_out, pin_oe, valid, fetch_ext, rsv;
  bts_mode_e   mode;
  logic [6:0]  mq[$];
  logic [1:0]  pq[$];
  logic [31:0] lfsr       = 32'h7547;
  int          fails      = 0;
  int          cmp_count  = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  bts_boot_mode_select i_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .eprom_boot_select_i(eprom_sel), .link_boot_select_i(link_sel),
    .boot_memory_select_i(pin), .boot_memory_select_o(pin_out),
    .boot_memory_select_oe_o(pin_oe), .bus_master_i(bus_master),
    .boot_cs_req_i(cs_req), .boot_mode_o(mode), .mode_valid_o(valid),
    .fetch_external_o(fetch_ext), .cfg_reserved_o(rsv));

  bts_strap_model i_strap (
    .strap_i(strap), .drv_oe_i(pin_oe), .drv_out_i(pin_out),
    .pin_o(pin));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected {mode, fetch external, reserved} for a code
  function automatic logic [6:0] exp_mode(input logic [2:0] c);
    casez (c)
      3'b10?:         return {BTS_MODE_EPROM, 2'h0};
      3'b11?, 3'b010: return {BTS_MODE_RESERVED, 2'h1};
      3'b011:         return {BTS_MODE_LINK, 2'h0};
      3'b001:         return {BTS_MODE_HOST, 2'h0};
      default:        return {BTS_MODE_NONE, 2'h2};
    endcase
  endfunction

  task automatic chk(input logic [6:0] got, input logic [6:0] exp,
                     input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // Output watcher
  // ****************************************
  always @(posedge clk_sys_i) begin
    #1;
    if (valid === 1'b1 && valid_q !== 1'b1 && mq.size() > 0)
      chk({mode, fetch_ext, rsv}, mq.pop_front(), "capture");
    valid_q = valid;
    if (pin_on && pq.size() > 0)
      chk({5'h00, pin_oe, pin_out}, {5'h00, pq.pop_front()}, "pin");
  end

  // ****************************************
  // Driver
  // ****************************************
  task automatic run_code(input logic [2:0] c);
    int n;
    n = 0;
    sys_rst_i = 1'b1;
    {eprom_sel, link_sel, strap} = c;
    bus_master = 1'b0;
    cs_req = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk({mode, valid, pin_oe}, {BTS_MODE_NONE, 2'h0}, "reset");
    mq.push_back(exp_mode(c));
    sys_rst_i = 1'b0;
    while (valid !== 1'b1 && n < 8) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (valid !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t no capture", $time);
      end_sim();
    end
    repeat (12) begin
      lfsr = lfsr_next(lfsr);
      bus_master = lfsr[0];
      cs_req = lfsr[1];
      pq.push_back(c[2:1] == 2'h2 ? {lfsr[0], ~(lfsr[0] & lfsr[1])} : 2'h1);
      pin_on = 1'b1;
      @(negedge clk_sys_i);
    end
    pin_on = 1'b0;
    {eprom_sel, link_sel, strap} = ~c;
    repeat (3) @(negedge clk_sys_i);
    chk({mode, fetch_ext, rsv}, exp_mode(c), "hold");
    $display("test code %0d done", c);
  endtask

  initial begin
    for (int i = 0; i < 8; i++) run_code(3'(i));
    if (mq.size() != 0 || pq.size() != 0) begin
      fails++;
      $display("[FAIL] %0t results missing", $time);
    end
    end_sim();
  end
endmodule // tb_boot_mode_select
